/* shared/sadc_map.vh */
`ifndef SADC_MAP_VH
`define SADC_MAP_VH

// bus geometry
`define SADC_AW 6
`define SADC_DW 16
`define SADC_RST16 16'h0000

// register offsets (word addresses)
`define SADC_OFF_CTRL1 6'h00
`define SADC_OFF_CTRL2 6'h01
`define SADC_OFF_CTRL3 6'h02
`define SADC_OFF_CHSEL 6'h03
`define SADC_BUF_HI 2'h1
`define SADC_BUF_MSB 5
`define SADC_BUF_LSB 4

// control register one fields
`define SADC_C1_EN 15
`define SADC_C1_IDLE 13
`define SADC_C1_RESULT_FORMAT_HI 9
`define SADC_C1_RESULT_FORMAT_LO 8
`define SADC_C1_TRIG_HI 7
`define SADC_C1_TRIG_LO 5
`define SADC_C1_AUTO_SAMPLE_START 2
`define SADC_C1_SAMPLE_ENABLE 1
`define SADC_C1_DONE 0

// control register two fields
`define SADC_C2_REF_HI 15
`define SADC_C2_REF_LO 13
`define SADC_C2_OFFSET_CALIBRATION_SELECT 12
`define SADC_C2_SCAN 10
`define SADC_C2_BUFFER_FILL_STATUS 7
`define SADC_C2_RATE_HI 5
`define SADC_C2_RATE_LO 2
`define SADC_C2_SPLIT 1
`define SADC_C2_ALTERNATE_MUX_SELECT 0

// control register three fields
`define SADC_C3_CLKSRC 15
`define SADC_C3_SAMT_HI 12
`define SADC_C3_SAMT_LO 8
`define SADC_C3_DIV_HI 7
`define SADC_C3_DIV_LO 0

// channel select fields
`define SADC_CH_A_HI 4
`define SADC_CH_A_LO 0
`define SADC_CH_B_HI 12
`define SADC_CH_B_LO 8

// writable masks (unimplemented bits read zero)
`define SADC_C1_WMASK 16'hA3E7
`define SADC_C2_WMASK 16'hF43F
`define SADC_C3_WMASK 16'h9FFF
`define SADC_CH_WMASK 16'h1F1F

// trigger source codes
`define SADC_TRIG_SW 3'h0
`define SADC_TRIG_PIN 3'h1
`define SADC_TRIG_TMR 3'h2
`define SADC_TRIG_CHARGE_TIME_MEASURE_UNIT 3'h6
`define SADC_TRIG_AUTO 3'h7

// result format codes
`define SADC_FMT_INT 2'h0
`define SADC_FMT_SINT 2'h1
`define SADC_FMT_FRAC 2'h2
`define SADC_FMT_SFRAC 2'h3

// reference codes
`define SADC_REF_POS 3'h1
`define SADC_REF_NEG 3'h2
`define SADC_REF_BOTH 3'h3

// channel numbers and misc
`define SADC_CH_MAX_LOW 5'h05
`define SADC_CH_MIN_HIGH 5'h0A
`define SADC_CH_MAX_HIGH 5'h0C
`define SADC_SIGN_FLIP 10'h200
`define SADC_ONE4 4'h1
`define SADC_ONE5 5'h01
`define SADC_ONE8 8'h01
`define SADC_ZERO3 3'h0
`define SADC_ZERO4 4'h0
`define SADC_ZERO5 5'h00
`define SADC_ZERO6 6'h00
`define SADC_ZERO8 8'h00

`endif

/* verilog/sadc_buf.v */
`timescale 1ns/1ps
`include "sadc_map.vh"

module sadc_buf (
   // clock and reset
   input wire core_clk_in,
   input wire rst_n_in,
   // write port from the sequencer
   input wire wr_en_in,
   input wire [3:0] wr_addr_in,
   input wire [15:0] wr_data_in,
   // read port from the bus
   input wire rd_en_in,
   input wire [3:0] rd_addr_in,
   input wire bypass_sel_in,
   input wire [15:0] bypass_data_in,
   output reg [15:0] rd_data_q_out
);

   reg [15:0] mem [0:15];

   // storage array, no reset so it maps to plain memory
   always @(posedge core_clk_in) begin
      if (wr_en_in) begin
         mem[wr_addr_in] <= wr_data_in;
      end
   end

   // read data register doubles as the bus read register
   always @(posedge core_clk_in) begin
      if (!rst_n_in) begin
         rd_data_q_out <= `SADC_RST16;
      end else if (rd_en_in) begin
         if (bypass_sel_in) begin
            rd_data_q_out <= bypass_data_in;
         end else begin
            rd_data_q_out <= mem[rd_addr_in];
         end
      end else begin
         rd_data_q_out <= `SADC_RST16; // data stand one cycle only
      end
   end

endmodule // sadc_buf

/* verilog/sadc_ctrl.v */
// What this block does
// - converter runs only while enable set
// - disabling may lose buffer; read first
// - idle-stop halts converter during CPU idle
// - two-bit format places ten-bit result
// - code 111: sample counter starts conversion
// - codes 110/010/001: event starts conversion
// - code 000: clearing sample bit converts
// - auto-start resamples, hardware sets sample bit
// - manual mode samples when software sets
// - sample bit shows sampling versus holding
// - done bit set on completion
// - reference select in control two 15:13
// - divider 7:0, sample time 12:8
// - interrupt rate in control two 5:2
// - sixteen word result buffer
// - nine channels: 0-5 and 10-12
// - interrupt every N+1 sequences
// - split mode gives two halves
// - fill status shows upper half filling
// - reference codes pick rails or pins
`timescale 1ns/1ps
`include "sadc_map.vh"

module sadc_ctrl (
   // clock and reset
   input wire core_clk_in,
   input wire rst_n_in,
   // register port
   input wire [5:0] reg_addr_in,
   input wire [15:0] reg_wdata_in,
   input wire reg_wr_in,
   input wire reg_rd_in,
   output wire [15:0] reg_rdata_out,
   // system state and trigger events
   input wire cpu_idle_in,
   input wire timer_three_match_in,
   input wire charge_time_measure_unit_event_in,
   input wire external_interrupt_pin_zero_in,
   // converter core
   input wire conv_done_in,
   input wire [9:0] conv_result_in,
   output reg converter_enable_out,
   output reg sample_hold_out,
   output reg conv_start_out,
   output reg [4:0] channel_out,
   output reg vref_pos_ext_out,
   output reg vref_neg_ext_out,
   output reg offset_cal_out,
   output reg [7:0] conv_clk_div_out,
   // interrupt request toward the interrupt controller
   output reg converter_interrupt_flag_out
);

   // one-hot sequencer states
   localparam [2:0] ST_HOLD = 3'h1;
   localparam [2:0] ST_SAMPLE = 3'h2;
   localparam [2:0] ST_CONV = 3'h4;

   reg [15:0] ctrl1_q;
   reg [15:0] ctrl2_q;
   reg [15:0] ctrl3_q;
   reg [15:0] chsel_q;
   reg [2:0] state_q;
   reg [7:0] tad_cnt_q;
   reg [4:0] samt_cnt_q;
   reg [3:0] seq_cnt_q;
   reg [3:0] ptr_q;
   reg buffer_fill_status_q;
   reg alt_q;
   reg pin_s1_q;
   reg pin_s2_q;
   reg pin_s3_q;
   reg pin_lvl_q;

   // field views
   wire en = ctrl1_q[`SADC_C1_EN];
   wire idle_stop_select = ctrl1_q[`SADC_C1_IDLE];
   wire [1:0] result_format = ctrl1_q[`SADC_C1_RESULT_FORMAT_HI:`SADC_C1_RESULT_FORMAT_LO];
   wire [2:0] trigger_source_select = ctrl1_q[`SADC_C1_TRIG_HI:`SADC_C1_TRIG_LO];
   wire auto_sample_start = ctrl1_q[`SADC_C1_AUTO_SAMPLE_START];
   wire [2:0] reference_select = ctrl2_q[`SADC_C2_REF_HI:`SADC_C2_REF_LO];
   wire [3:0] interrupt_rate_select = ctrl2_q[`SADC_C2_RATE_HI:`SADC_C2_RATE_LO];
   wire buffer_split_mode = ctrl2_q[`SADC_C2_SPLIT];
   wire alternate_mux_select = ctrl2_q[`SADC_C2_ALTERNATE_MUX_SELECT];
   wire [4:0] auto_sample_time = ctrl3_q[`SADC_C3_SAMT_HI:`SADC_C3_SAMT_LO];
   wire [7:0] conversion_clock_divider = ctrl3_q[`SADC_C3_DIV_HI:`SADC_C3_DIV_LO];

   // address decode
   wire hit_c1 = (reg_addr_in == `SADC_OFF_CTRL1);
   wire hit_c2 = (reg_addr_in == `SADC_OFF_CTRL2);
   wire hit_c3 = (reg_addr_in == `SADC_OFF_CTRL3);
   wire hit_ch = (reg_addr_in == `SADC_OFF_CHSEL);
   wire hit_buf = (reg_addr_in[`SADC_BUF_MSB:`SADC_BUF_LSB] == `SADC_BUF_HI);
   wire wr_c1 = reg_wr_in & hit_c1;
   wire sw_sample_enable = reg_wdata_in[`SADC_C1_SAMPLE_ENABLE];

   // idle stop freezes progress, state is kept for resume
   wire run = en & ~(idle_stop_select & cpu_idle_in);

   // external pin: change accepted once stages two and three agree
   always @(posedge core_clk_in) begin
      if (!rst_n_in) begin
         pin_s1_q <= 1'b0;
         pin_s2_q <= 1'b0;
         pin_s3_q <= 1'b0;
         pin_lvl_q <= 1'b0;
      end else begin
         pin_s1_q <= external_interrupt_pin_zero_in;
         pin_s2_q <= pin_s1_q;
         pin_s3_q <= pin_s2_q;
         if (pin_s2_q == pin_s3_q) begin
            pin_lvl_q <= pin_s3_q;
         end
      end
   end
   wire pin_rise = (pin_s2_q == pin_s3_q) & pin_s3_q & ~pin_lvl_q;

   // sample timer: one tad is divider+1 clocks
   wire tad_tick = (tad_cnt_q == conversion_clock_divider);
   wire samt_expired = (samt_cnt_q == auto_sample_time);

   // conversion trigger from the selected source
   reg trig_hit;
   always @* begin
      trig_hit = 1'b0;
      case (trigger_source_select)
         `SADC_TRIG_AUTO: trig_hit = samt_expired;
         `SADC_TRIG_CHARGE_TIME_MEASURE_UNIT: trig_hit = charge_time_measure_unit_event_in;
         `SADC_TRIG_TMR: trig_hit = timer_three_match_in;
         `SADC_TRIG_PIN: trig_hit = pin_rise;
         `SADC_TRIG_SW: trig_hit = wr_c1 & ~sw_sample_enable;
         default: trig_hit = 1'b0; // reserved codes never trigger
      endcase
   end

   function [15:0] fmt_result;
      input [1:0] fmt;
      input [9:0] r;
      reg [9:0] s;
      begin
         s = r ^ `SADC_SIGN_FLIP;
         case (fmt)
            `SADC_FMT_SINT: fmt_result = {{6{s[9]}}, s};
            `SADC_FMT_FRAC: fmt_result = {r, `SADC_ZERO6};
            `SADC_FMT_SFRAC: fmt_result = {s, `SADC_ZERO6};
            default: fmt_result = {`SADC_ZERO6, r};
         endcase
      end
   endfunction

   // completion bookkeeping; a result already in flight lands even under idle stop
   wire conv_fin = en & (state_q == ST_CONV) & conv_done_in;
   wire seq_last = (seq_cnt_q == interrupt_rate_select);
   // split mode addresses the half being filled
   wire [3:0] wr_addr = buffer_split_mode ? {buffer_fill_status_q, ptr_q[2:0]} : ptr_q;

   // map the selected code to a legal channel, others park on channel zero
   function [4:0] legal_chan;
      input [4:0] c;
      begin
         if ((c <= `SADC_CH_MAX_LOW) ||
             ((c >= `SADC_CH_MIN_HIGH) && (c <= `SADC_CH_MAX_HIGH))) begin
            legal_chan = c;
         end else begin
            legal_chan = `SADC_ZERO5;
         end
      end
   endfunction
   wire [4:0] chan_sel = (alternate_mux_select & alt_q) ?
                         chsel_q[`SADC_CH_B_HI:`SADC_CH_B_LO] :
                         chsel_q[`SADC_CH_A_HI:`SADC_CH_A_LO];

   // control registers, sequencer and counters
   always @(posedge core_clk_in) begin
      if (!rst_n_in) begin
         ctrl1_q <= `SADC_RST16;
         ctrl2_q <= `SADC_RST16;
         ctrl3_q <= `SADC_RST16;
         chsel_q <= `SADC_RST16;
         state_q <= ST_HOLD;
         tad_cnt_q <= `SADC_ZERO8;
         samt_cnt_q <= `SADC_ZERO5;
         seq_cnt_q <= `SADC_ZERO4;
         ptr_q <= `SADC_ZERO4;
         buffer_fill_status_q <= 1'b0;
         alt_q <= 1'b0;
         conv_start_out <= 1'b0;
         converter_interrupt_flag_out <= 1'b0;
      end else begin
         conv_start_out <= 1'b0;
         converter_interrupt_flag_out <= 1'b0;
         // software writes; status bits are merged below
         if (wr_c1) begin
            ctrl1_q <= reg_wdata_in & `SADC_C1_WMASK;
         end
         if (reg_wr_in & hit_c2) begin
            ctrl2_q <= (reg_wdata_in & `SADC_C2_WMASK) |
                       {8'h00, buffer_fill_status_q, 7'h00};
         end else begin
            // fill status tracks the half in use
            ctrl2_q[`SADC_C2_BUFFER_FILL_STATUS] <= buffer_fill_status_q;
         end
         if (reg_wr_in & hit_c3) begin
            ctrl3_q <= reg_wdata_in & `SADC_C3_WMASK;
         end
         if (reg_wr_in & hit_ch) begin
            chsel_q <= reg_wdata_in & `SADC_CH_WMASK;
         end
         if (!en) begin
            // converter off; sequence and buffer position are lost
            state_q <= ST_HOLD;
            ctrl1_q[`SADC_C1_SAMPLE_ENABLE] <= 1'b0;
            seq_cnt_q <= `SADC_ZERO4;
            ptr_q <= `SADC_ZERO4;
            buffer_fill_status_q <= 1'b0;
            alt_q <= 1'b0;
         end else if (run | conv_fin) begin
            case (state_q)
               ST_HOLD: begin
                  // manual start when software sets the sample bit
                  if (wr_c1 & sw_sample_enable) begin
                     state_q <= ST_SAMPLE;
                     tad_cnt_q <= `SADC_ZERO8;
                     samt_cnt_q <= `SADC_ZERO5;
                     // hardware clears done as a new sample begins
                     ctrl1_q[`SADC_C1_DONE] <= 1'b0;
                  end
               end
               ST_SAMPLE: begin
                  if (trig_hit) begin
                     state_q <= ST_CONV;
                     ctrl1_q[`SADC_C1_SAMPLE_ENABLE] <= 1'b0;
                     conv_start_out <= 1'b1;
                  end else if (wr_c1 & ~sw_sample_enable) begin
                     state_q <= ST_HOLD; // sample aborted by software
                  end else if (tad_tick) begin
                     tad_cnt_q <= `SADC_ZERO8;
                     if (!samt_expired) begin
                        samt_cnt_q <= samt_cnt_q + `SADC_ONE5;
                     end
                  end else begin
                     tad_cnt_q <= tad_cnt_q + `SADC_ONE8;
                  end
               end
               ST_CONV: begin
                  if (conv_done_in) begin
                     // done set; wins over a software clear
                     ctrl1_q[`SADC_C1_DONE] <= 1'b1;
                     if (alternate_mux_select) begin
                        alt_q <= ~alt_q;
                     end
                     if (seq_last) begin
                        converter_interrupt_flag_out <= 1'b1;
                        seq_cnt_q <= `SADC_ZERO4;
                        ptr_q <= `SADC_ZERO4;
                        alt_q <= 1'b0;
                        if (buffer_split_mode) begin
                           buffer_fill_status_q <= ~buffer_fill_status_q;
                        end
                     end else begin
                        seq_cnt_q <= seq_cnt_q + `SADC_ONE4;
                        ptr_q <= ptr_q + `SADC_ONE4;
                     end
                     // auto-start resamples and sets the sample bit
                     if (ctrl1_q[`SADC_C1_AUTO_SAMPLE_START] | (wr_c1 & reg_wdata_in[`SADC_C1_AUTO_SAMPLE_START])) begin
                        state_q <= ST_SAMPLE;
                        ctrl1_q[`SADC_C1_SAMPLE_ENABLE] <= 1'b1;
                        tad_cnt_q <= `SADC_ZERO8;
                        samt_cnt_q <= `SADC_ZERO5;
                     end else begin
                        state_q <= ST_HOLD;
                     end
                  end else begin
                     // sample bit written during conversion has no effect
                     ctrl1_q[`SADC_C1_SAMPLE_ENABLE] <= 1'b0;
                  end
               end
               default: state_q <= ST_HOLD;
            endcase
         end
      end
   end

   // outputs toward the analog core
   always @(posedge core_clk_in) begin
      if (!rst_n_in) begin
         converter_enable_out <= 1'b0;
         sample_hold_out <= 1'b0;
         channel_out <= `SADC_ZERO5;
         vref_pos_ext_out <= 1'b0;
         vref_neg_ext_out <= 1'b0;
         offset_cal_out <= 1'b0;
         conv_clk_div_out <= `SADC_ZERO8;
      end else begin
         converter_enable_out <= run;
         sample_hold_out <= run & ctrl1_q[`SADC_C1_SAMPLE_ENABLE];
         channel_out <= legal_chan(chan_sel);
         // reference pins, codes 1xx fall back to rails
         vref_pos_ext_out <= (reference_select == `SADC_REF_POS) |
                             (reference_select == `SADC_REF_BOTH);
         vref_neg_ext_out <= (reference_select == `SADC_REF_NEG) |
                             (reference_select == `SADC_REF_BOTH);
         offset_cal_out <= ctrl2_q[`SADC_C2_OFFSET_CALIBRATION_SELECT];
         // divider passed on for the conversion clock
         conv_clk_div_out <= conversion_clock_divider;
      end
   end

   // register read mux; buffer reads as zero while disabled
   reg [15:0] reg_view;
   reg bypass;
   always @* begin
      bypass = 1'b1;
      if (hit_c1) begin
         reg_view = ctrl1_q;
      end else if (hit_c2) begin
         reg_view = ctrl2_q;
      end else if (hit_c3) begin
         reg_view = ctrl3_q;
      end else if (hit_ch) begin
         reg_view = chsel_q;
      end else if (hit_buf & en) begin
         reg_view = `SADC_RST16;
         bypass = 1'b0;
      end else begin
         reg_view = `SADC_RST16;
      end
   end

   sadc_buf u_buf (
      .core_clk_in(core_clk_in),
      .rst_n_in(rst_n_in),
      .wr_en_in(conv_fin),
      .wr_addr_in(wr_addr),
      .wr_data_in(fmt_result(result_format, conv_result_in)),
      .rd_en_in(reg_rd_in),
      .rd_addr_in(reg_addr_in[3:0]),
      .bypass_sel_in(bypass),
      .bypass_data_in(reg_view),
      .rd_data_q_out(reg_rdata_out)
   );

endmodule // sadc_ctrl

/* dv/sadc_ctrl_asserts.sv */
`timescale 1ns/1ps
`include "sadc_map.vh"

module sadc_ctrl_asserts (
   // clock, reset and register port
   input wire core_clk_in,
   input wire rst_n_in,
   input wire [5:0] reg_addr_in,
   input wire [15:0] reg_wdata_in,
   input wire reg_wr_in,
   input wire reg_rd_in,
   input wire [15:0] reg_rdata_out,
   // system state and converter side
   input wire cpu_idle_in,
   input wire conv_done_in,
   input wire converter_enable_out,
   input wire sample_hold_out,
   input wire conv_start_out,
   input wire vref_pos_ext_out,
   input wire vref_neg_ext_out,
   input wire [7:0] conv_clk_div_out,
   input wire converter_interrupt_flag_out
);
   reg en_q, idle_q, auto_sample_start_q;
   reg [3:0] rate_q;
   reg [2:0] ref_q;
   reg [7:0] div_q;
   // decoded writes and the halted condition
   wire wr1 = reg_wr_in && reg_addr_in == `SADC_OFF_CTRL1;
   wire wr2 = reg_wr_in && reg_addr_in == `SADC_OFF_CTRL2;
   wire wr3 = reg_wr_in && reg_addr_in == `SADC_OFF_CTRL3;
   wire stop = !en_q || (idle_q && cpu_idle_in);
   default clocking cb @(posedge core_clk_in); endclocking
   default disable iff (!rst_n_in);

   // shadow fields, updated on the same edge as the design's registers
   always @(posedge core_clk_in) begin
      if (!rst_n_in) begin
         {en_q, idle_q, auto_sample_start_q, rate_q, ref_q, div_q} <= 18'h00000;
      end else begin
         if (wr1) begin
            en_q <= reg_wdata_in[15];
            idle_q <= reg_wdata_in[13];
            auto_sample_start_q <= reg_wdata_in[2];
         end
         if (wr2) begin
            rate_q <= reg_wdata_in[5:2];
            ref_q <= reg_wdata_in[15:13];
         end
         if (wr3) begin
            div_q <= reg_wdata_in[7:0];
         end
      end
   end

   AST_RUN_ON:
   assert property (!stop [*3] |-> converter_enable_out) else $error("converter not running");
   AST_RUN_OFF:
   assert property (stop [*3] |-> !converter_enable_out) else $error("converter not halted");
   AST_SW_TRIG:
   assert property (wr1 && reg_wdata_in[15] && reg_wdata_in[7:5] == 3'h0 && !reg_wdata_in[1]
      && sample_hold_out && converter_enable_out && !cpu_idle_in |=> conv_start_out)
      else $error("clearing sample bit did not convert");
   AST_AUTO_RESAMPLE:
   assert property (conv_done_in && auto_sample_start_q && !stop && converter_enable_out
      |-> ##[1:3] sample_hold_out) else $error("no automatic resample");
   AST_HOLD_AT_START:
   assert property (conv_start_out |=> !sample_hold_out) else $error("still sampling");
   AST_IRQ_EVERY:
   assert property (conv_done_in && !stop && converter_enable_out && rate_q == 4'h0
      |=> converter_interrupt_flag_out) else $error("interrupt missing");
   AST_IRQ_CAUSE:
   assert property (converter_interrupt_flag_out |-> $past(conv_done_in))
      else $error("interrupt without completion");
   AST_REF_SEL:
   assert property (wr2 |=> ##1 vref_pos_ext_out == (ref_q == 3'h1 || ref_q == 3'h3)
      && vref_neg_ext_out == (ref_q == 3'h2 || ref_q == 3'h3)) else $error("bad reference");
   AST_DIV_FIELD:
   assert property (wr3 |=> ##1 conv_clk_div_out == div_q) else $error("bad divider");
   AST_BUF_OFF:
   assert property (reg_rd_in && reg_addr_in[5:4] == 2'h1 && !en_q
      |=> reg_rdata_out == 16'h0000) else $error("buffer readable while off");

   // main scenarios reached
   COV_IRQ: cover property (converter_interrupt_flag_out);
   COV_IDLE: cover property (cpu_idle_in && idle_q && en_q);
   COV_SPLIT: cover property (wr2 && reg_wdata_in[1]);
endmodule // sadc_ctrl_asserts

/* dv/sadc_core_model.sv */
`timescale 1ns/1ps

module sadc_core_model #(
   parameter LAT = 6
) (
   // clock and reset
   input wire core_clk_in,
   input wire rst_n_in,
   // control from the sequencer
   input wire conv_start_in,
   input wire enable_in,
   input wire [9:0] value_in,
   // answer toward the sequencer
   output reg conv_done_out,
   output reg [9:0] conv_result_out
);
   int cnt_q;
   // counts only while powered; result lines carry junk outside the done cycle
   always @(posedge core_clk_in) begin
      conv_done_out <= 1'b0;
      conv_result_out <= ~value_in;
      if (!rst_n_in) begin
         cnt_q <= 0;
      end else if (conv_start_in) begin
         cnt_q <= LAT;
      end else if (enable_in && cnt_q == 1) begin
         conv_done_out <= 1'b1;
         conv_result_out <= value_in;
         cnt_q <= 0;
      end else if (enable_in && cnt_q > 1) begin
         cnt_q <= cnt_q - 1;
      end
   end
endmodule // sadc_core_model

/* dv/sar_adc_sequencer_control_tb.sv */
`timescale 1ns/1ps
`include "sadc_map.vh"

`define CHK(got, exp) begin \
   comparisons++; \
   if ((got) !== (exp)) begin \
      n_errors++; \
      $display("wrong value at %0t: got %h want %h", $time, got, exp); \
   end \
end

module sar_adc_sequencer_control_tb;
   localparam [5:0] a_c1 = `SADC_OFF_CTRL1;
   localparam [5:0] a_c2 = `SADC_OFF_CTRL2;
   localparam [5:0] a_c3 = `SADC_OFF_CTRL3;
   localparam [5:0] a_buf = 6'h10;
   reg core_clk_in = 1'b0;
   reg rst_n_in = 1'b0;
   reg [5:0] reg_addr = 6'h00;
   reg [15:0] reg_wdata = 16'h0000;
   reg reg_wr = 1'b0;
   reg reg_rd = 1'b0;
   reg cpu_idle = 1'b0;
   reg tmr_match = 1'b0;
   reg charge_time_measure_unit_event = 1'b0;
   reg pin_zero = 1'b0;
   reg [9:0] core_value = 10'h1A3;
   reg [2:0] trig [4] = '{3'h1, 3'h2, 3'h6, 3'h7};
   wire [15:0] reg_rdata_out;
   wire [9:0] conv_result;
   wire [7:0] conv_clk_div_out;
   wire [4:0] channel_out;
   wire offset_cal_out;
   wire conv_done, converter_enable_out, sample_hold_out, conv_start_out;
   wire vref_pos_ext_out, vref_neg_ext_out, converter_interrupt_flag_out;
   int n_errors = 0;
   int comparisons = 0;
   int irq_cnt = 0;
   int start_cnt = 0;
   int k, s0;

   // 250 MHz clock
   initial forever #2 core_clk_in = ~core_clk_in;

   sadc_ctrl dut_u (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .reg_addr_in(reg_addr),
      .reg_wdata_in(reg_wdata), .reg_wr_in(reg_wr), .reg_rd_in(reg_rd),
      .reg_rdata_out(reg_rdata_out), .cpu_idle_in(cpu_idle), .timer_three_match_in(tmr_match),
      .charge_time_measure_unit_event_in(charge_time_measure_unit_event), .external_interrupt_pin_zero_in(pin_zero),
      .conv_done_in(conv_done), .conv_result_in(conv_result),
      .converter_enable_out(converter_enable_out), .sample_hold_out(sample_hold_out),
      .conv_start_out(conv_start_out), .channel_out(channel_out),
      .vref_pos_ext_out(vref_pos_ext_out), .vref_neg_ext_out(vref_neg_ext_out),
      .offset_cal_out(offset_cal_out), .conv_clk_div_out(conv_clk_div_out),
      .converter_interrupt_flag_out(converter_interrupt_flag_out));

   sadc_core_model #(.LAT(6)) core_u (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in),
      .conv_start_in(conv_start_out), .enable_in(converter_enable_out),
      .value_in(core_value), .conv_done_out(conv_done), .conv_result_out(conv_result));

   // pulse counts; sampled on the edge so a one-cycle pulse counts once
   always @(posedge core_clk_in) begin
      if (converter_interrupt_flag_out === 1'b1) irq_cnt++;
      if (conv_start_out === 1'b1) start_cnt++;
   end

   task automatic finish_test();
      $display("comparisons %0d, mismatches %0d", comparisons, n_errors);
      if (n_errors == 0 && comparisons > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   task automatic wr(input [5:0] a, input [15:0] d);
      @(posedge core_clk_in);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge core_clk_in);
      reg_wr <= 1'b0;
   endtask

   // read data stand only in the cycle after the strobe
   task automatic rd_chk(input [5:0] a, input [15:0] exp);
      @(posedge core_clk_in);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge core_clk_in);
      reg_rd <= 1'b0;
      @(negedge core_clk_in);
      `CHK(reg_rdata_out, exp)
   endtask

   task automatic wait_done();
      int i;
      for (i = 0; i < 200 && conv_done !== 1'b1; i++) @(negedge core_clk_in);
      if (i == 200) begin
         n_errors++;
         $display("wrong value at %0t: no conversion result", $time);
         finish_test();
      end
      repeat (2) @(negedge core_clk_in);
   endtask

   // pin stays high until the next call, so only its rise is an event
   task automatic fire(input [2:0] c);
      @(posedge core_clk_in);
      tmr_match <= (c == 3'h2);
      charge_time_measure_unit_event <= (c == 3'h6);
      pin_zero <= (c == 3'h1);
      @(posedge core_clk_in);
      tmr_match <= 1'b0;
      charge_time_measure_unit_event <= 1'b0;
   endtask

   function automatic [15:0] fmt(input [1:0] f, input [9:0] r);
      reg [9:0] s;
      s = r ^ 10'h200;
      case (f)
         2'h0: fmt = {6'h00, r};
         2'h1: fmt = {{6{s[9]}}, s};
         2'h2: fmt = {r, 6'h00};
         default: fmt = {s, 6'h00};
      endcase
   endfunction

   initial begin
      repeat (20) @(posedge core_clk_in);
      rst_n_in <= 1'b1;
      rd_chk(a_c1, 16'h0000);
      wr(a_c3, 16'hFFFF);
      rd_chk(a_c3, 16'h9FFF);
      `CHK(conv_clk_div_out, 8'hFF)
      wr(6'h3F, 16'hFFFF);
      rd_chk(6'h3F, 16'h0000);
      wr(a_c2, 16'hFFFF);
      rd_chk(a_c2, 16'hF43F);
      `CHK(offset_cal_out, 1'b1)
      rd_chk(a_buf, 16'h0000);
      for (k = 0; k < 8; k++) begin
         wr(a_c2, {k[2:0], 13'h0000});
         repeat (2) @(negedge core_clk_in);
         `CHK(vref_pos_ext_out, k == 1 || k == 3)
         `CHK(vref_neg_ext_out, k == 2 || k == 3)
      end
      wr(6'h03, 16'h0A0C);
      repeat (2) @(negedge core_clk_in);
      `CHK(channel_out, 5'h0C)
      wr(6'h03, 16'h0008);
      repeat (2) @(negedge core_clk_in);
      `CHK(channel_out, 5'h00)
      $display("test registers done");
      wr(a_c3, 16'h0201);
      wr(a_c2, 16'h000C);
      wr(a_c1, 16'h8000);
      for (k = 0; k < 4; k++) begin
         wr(a_c1, {6'h20, k[1:0], 8'h02});
         repeat (3) @(posedge core_clk_in);
         wr(a_c1, {6'h20, k[1:0], 8'h00});
         wait_done();
         `CHK(sample_hold_out, 1'b0)
         rd_chk(a_c1, {6'h20, k[1:0], 8'h01});
      end
      `CHK(irq_cnt, 1)
      for (k = 0; k < 4; k++) rd_chk(a_buf + k[5:0], fmt(k[1:0], 10'h1A3));
      $display("test formats done");
      wr(a_c2, 16'h0002);
      for (k = 0; k < 4; k++) begin
         wr(a_c1, {8'h80, trig[k], 5'h02});
         core_value <= 10'h100 + k[9:0];
         s0 = start_cnt;
         if (trig[k] != 3'h7) begin
            fire(trig[k] == 3'h6 ? 3'h2 : 3'h6);
            repeat (8) @(negedge core_clk_in);
            `CHK(start_cnt, s0)
            fire(trig[k]);
         end
         wait_done();
         `CHK(start_cnt, s0 + 1)
         rd_chk(a_c2, {8'h00, ~k[0], 7'h02});
         rd_chk(a_buf + {2'h0, k[0], 3'h0}, {6'h00, 10'h100 + k[9:0]});
      end
      $display("test triggers done");
      wr(a_c2, 16'h0000);
      s0 = irq_cnt;
      wr(a_c1, 16'hA0E6);
      repeat (60) @(negedge core_clk_in);
      `CHK(irq_cnt - s0 >= 3, 1'b1)
      @(posedge core_clk_in);
      cpu_idle <= 1'b1;
      repeat (4) @(negedge core_clk_in);
      s0 = start_cnt;
      repeat (40) @(negedge core_clk_in);
      `CHK(converter_enable_out, 1'b0)
      `CHK(start_cnt, s0)
      wr(a_c1, 16'h80E6);
      repeat (40) @(negedge core_clk_in);
      `CHK(start_cnt > s0, 1'b1)
      @(posedge core_clk_in);
      cpu_idle <= 1'b0;
      wr(a_c1, 16'h0000);
      rd_chk(a_buf, 16'h0000);
      `CHK(converter_enable_out, 1'b0)
      $display("test auto done");
      finish_test();
   end
endmodule // sar_adc_sequencer_control_tb

bind sadc_ctrl sadc_ctrl_asserts chk_u (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in),
   .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
   .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out), .cpu_idle_in(cpu_idle_in),
   .conv_done_in(conv_done_in), .converter_enable_out(converter_enable_out),
   .sample_hold_out(sample_hold_out), .conv_start_out(conv_start_out),
   .vref_pos_ext_out(vref_pos_ext_out), .vref_neg_ext_out(vref_neg_ext_out),
   .conv_clk_div_out(conv_clk_div_out),
   .converter_interrupt_flag_out(converter_interrupt_flag_out));
